// ===== logic/ssp_ctrl_top.sv
// Serial port control register block with AXI4-Lite access and interrupt logic.
`timescale 1ns/10ps
`default_nettype none
module ssp_ctrl_top
    import ssp_pkg::*;
#(
    parameter int AW = ADDR_W
)(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              txBusy,
    input  wire logic              rxByteDone,
    input  wire logic [7:0]        rxData,
    input  wire logic              startSeen,
    input  wire logic              stopSeen,
    output logic                   txLoad,
    output logic [7:0]             txData,
    output logic [3:0]             portMode,
    output ssp_mode_t              modeFlags,
    output ssp_route_t             pinRoute,
    output logic                   sckIdleHigh,
    output logic                   sclHold,
    output logic [10:0]            sckDivide,
    output logic                   irq
);

    if (AW < ADDR_W) begin : g_awCheck
        $error("ssp_ctrl_top: address width too small");
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    logic [AW-1:0] awAddr_q;
    logic          awHeld_q;
    logic [31:0]   wData_q;
    logic [3:0]    wStrb_q;
    logic          wHeld_q;
    logic          bValid_q;
    logic [1:0]    bResp_q;
    logic          doWrite;
    logic [4:0]    wOfs;
    logic          wLane0;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready  = !wHeld_q && !bValid_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign doWrite       = awHeld_q && wHeld_q && !bValid_q;
    assign wOfs          = awAddr_q[4:0];
    assign wLane0        = doWrite && wStrb_q[0];

    function automatic logic ofsMapped(input logic [AW-1:0] a);
        logic hit;
        hit = (a[4:0] == CTRL_OFS) || (a[4:0] == BUF_OFS) || (a[4:0] == BAUD_OFS)
            || (a[4:0] == STAT_OFS) || (a[4:0] == MASK_OFS);
        return hit && (a >> 5) == '0;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bValid_q <= 1'b0;
            bResp_q  <= RESP_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= ofsMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Control register, baud reload and transfer buffer
    // ------------------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] baud_q;
    logic [7:0] buf_q;
    logic       bufHeld_q;
    logic       bufRead;
    logic       bufWrite;
    logic       collide;
    logic       overflow;
    logic       ctrlWrite;

    assign ctrlWrite = wLane0 && wOfs == CTRL_OFS;
    assign bufWrite  = wLane0 && wOfs == BUF_OFS;
    assign collide   = bufWrite && txBusy;
    // An SPI master only receives on its own buffer write, so it never overruns.
    assign overflow  = rxByteDone && bufHeld_q && ctrl_q[EN_BIT] && !modeFlags.spiMaster
                       && (modeFlags.spiSlave || modeFlags.i2cSlave
                           || modeFlags.i2cMaster);

    // Software can only clear the two flags; a set in the same cycle wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (ctrlWrite) begin
                ctrl_q[5:0] <= wData_q[5:0];
            end
            if (collide) begin
                ctrl_q[WRITE_COLLISION_FLAG_BIT] <= 1'b1;
            end else if (ctrlWrite && !wData_q[WRITE_COLLISION_FLAG_BIT]) begin
                ctrl_q[WRITE_COLLISION_FLAG_BIT] <= 1'b0;
            end
            if (overflow) begin
                ctrl_q[OVF_BIT] <= 1'b1;
            end else if (ctrlWrite && !wData_q[OVF_BIT]) begin
                ctrl_q[OVF_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_q <= BAUD_RST;
        end else if (wLane0 && wOfs == BAUD_OFS) begin
            baud_q <= wData_q[7:0];
        end
    end

    // Received data only lands in an empty buffer; on overrun the new byte is dropped.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_q     <= BUF_RST;
            bufHeld_q <= 1'b0;
        end else if (rxByteDone && !bufHeld_q) begin
            buf_q     <= rxData;
            bufHeld_q <= 1'b1;
        end else if (bufRead) begin
            bufHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txLoad <= 1'b0;
            txData <= BUF_RST;
        end else begin
            txLoad <= bufWrite && !txBusy;
            if (bufWrite && !txBusy) begin
                txData <= wData_q[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode decode and serial clock control
    // ------------------------------------------------------------------------
    assign portMode  = ctrl_q[3:0];
    assign modeFlags = ssp_decode(ctrl_q[3:0]);

    ssp_pin_mux u_pin_mux (
        .portEnable (ctrl_q[EN_BIT]),
        .modeFlags  (modeFlags),
        .route      (pinRoute)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sckIdleHigh <= 1'b0;
            sclHold     <= 1'b0;
            sckDivide   <= DIV_NONE;
        end else begin
            sckIdleHigh <= ctrl_q[CKP_BIT] && (modeFlags.spiMaster || modeFlags.spiSlave);
            sclHold     <= ctrl_q[EN_BIT] && modeFlags.i2cSlave && !ctrl_q[CKP_BIT];
            sckDivide   <= ssp_divisor(ctrl_q[3:0], baud_q);
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] statSet;
    logic [IRQ_W-1:0] statClr;

    always_comb begin
        statSet            = '0;
        statSet[IRQ_COLL]  = collide;
        statSet[IRQ_OVF]   = overflow;
        statSet[IRQ_START] = startSeen && ctrl_q[EN_BIT] && modeFlags.startStopIrq;
        statSet[IRQ_STOP]  = stopSeen && ctrl_q[EN_BIT] && modeFlags.startStopIrq;
        statClr            = (wLane0 && wOfs == STAT_OFS) ? wData_q[IRQ_W-1:0] : '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
        end else begin
            stat_q <= statSet | (stat_q & ~statClr);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= MASK_RST;
        end else if (wLane0 && wOfs == MASK_OFS) begin
            mask_q <= wData_q[IRQ_W-1:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic [7:0]  rByte;

    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign bufRead       = s_axi_arvalid && s_axi_arready
                           && s_axi_araddr[4:0] == BUF_OFS && ofsMapped(s_axi_araddr);

    always_comb begin
        rByte = 8'h00;
        unique case (s_axi_araddr[4:0])
            CTRL_OFS: rByte = ctrl_q;
            BUF_OFS:  rByte = buf_q;
            BAUD_OFS: rByte = baud_q;
            STAT_OFS: rByte = {4'h0, stat_q};
            MASK_OFS: rByte = {4'h0, mask_q};
            default:  rByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rValid_q <= 1'b0;
            rData_q  <= '0;
            rResp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rData_q  <= ofsMapped(s_axi_araddr) ? {24'h000000, rByte} : '0;
            rResp_q  <= ofsMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_wcolSet;
        @(posedge clk) disable iff (rst)
        bufWrite && txBusy |=> ctrl_q[WRITE_COLLISION_FLAG_BIT] && !txLoad;
    endproperty
    a_wcolSet: assert property (p_wcolSet) else $error("collision flag not set");

    property p_ovfSlave;
        @(posedge clk) disable iff (rst)
        rxByteDone && bufHeld_q && ctrl_q[EN_BIT] && (modeFlags.spiSlave || modeFlags.i2cSlave)
        |=> ctrl_q[OVF_BIT] && buf_q == $past(buf_q) && stat_q[IRQ_OVF];
    endproperty
    a_ovfSlave: assert property (p_ovfSlave) else $error("overflow not flagged");

    property p_ovfNoMaster;
        @(posedge clk) disable iff (rst)
        $rose(ctrl_q[OVF_BIT]) |-> $past(rxByteDone) && !$past(modeFlags.spiMaster);
    endproperty
    a_ovfNoMaster: assert property (p_ovfNoMaster) else $error("overflow in master");

    property p_spiRoute;
        @(posedge clk) disable iff (rst)
        (modeFlags.spiMaster || modeFlags.spiSlave)
        |-> pinRoute.sck == ctrl_q[EN_BIT] && pinRoute.sdi == ctrl_q[EN_BIT] && !pinRoute.sda;
    endproperty
    a_spiRoute: assert property (p_spiRoute) else $error("spi pins misrouted");

    property p_i2cRoute;
        @(posedge clk) disable iff (rst)
        modeFlags.i2cSlave |-> pinRoute.scl == ctrl_q[EN_BIT] && !pinRoute.sck;
    endproperty
    a_i2cRoute: assert property (p_i2cRoute) else $error("i2c pins misrouted");

    property p_idleLevel;
        @(posedge clk) disable iff (rst)
        modeFlags.spiSlave ##1 modeFlags.spiSlave |-> sckIdleHigh == $past(ctrl_q[CKP_BIT]);
    endproperty
    a_idleLevel: assert property (p_idleLevel) else $error("idle level wrong");

    property p_startIrq;
        @(posedge clk) disable iff (rst)
        $rose(stat_q[IRQ_START]) |-> $past(startSeen && modeFlags.startStopIrq);
    endproperty
    a_startIrq: assert property (p_startIrq) else $error("start irq in wrong mode");

    property p_divisor;
        @(posedge clk) disable iff (rst)
        modeFlags.reloadDiv |=> sckDivide == 11'({$past(baud_q), 2'b00} + 11'h004);
    endproperty
    a_divisor: assert property (p_divisor) else $error("divisor wrong");

    property p_selRelease;
        @(posedge clk) disable iff (rst)
        portMode == MODE_SPI_S_NOSEL |-> !pinRoute.ss && modeFlags.ssDisabled;
    endproperty
    a_selRelease: assert property (p_selRelease) else $error("select pin not freed");

    property p_stretch;
        @(posedge clk) disable iff (rst)
        (ctrl_q[EN_BIT] && modeFlags.i2cSlave && !ctrl_q[CKP_BIT]) [*2] |-> sclHold;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not stretched");

    property p_reserved;
        @(posedge clk) disable iff (rst)
        modeFlags.reserved ##1 modeFlags.reserved |-> pinRoute == '0 && sckDivide == DIV_NONE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode active");

endmodule
`default_nettype wire

// ===== logic/ssp_pkg.sv
// Package with register map, mode codes and shared types of the serial port control block.
`default_nettype none
package ssp_pkg;

    // ------------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------------
    localparam int         ADDR_W    = 5;
    localparam logic [4:0] CTRL_OFS  = 5'h00;
    localparam logic [4:0] BUF_OFS   = 5'h04;
    localparam logic [4:0] BAUD_OFS  = 5'h08;
    localparam logic [4:0] STAT_OFS  = 5'h0c;
    localparam logic [4:0] MASK_OFS  = 5'h10;

    localparam int WRITE_COLLISION_FLAG_BIT = 7;
    localparam int OVF_BIT  = 6;
    localparam int EN_BIT   = 5;
    localparam int CKP_BIT  = 4;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] BUF_RST  = 8'h00;

    localparam int         IRQ_W     = 4;
    localparam int         IRQ_COLL  = 0;
    localparam int         IRQ_OVF   = 1;
    localparam int         IRQ_START = 2;
    localparam int         IRQ_STOP  = 3;
    localparam logic [3:0] MASK_RST  = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------------
    // Mode codes and clock divisors
    // ------------------------------------------------------------------------
    localparam logic [3:0] MODE_SPI_M_DIV4   = 4'h0;
    localparam logic [3:0] MODE_SPI_M_DIV16  = 4'h1;
    localparam logic [3:0] MODE_SPI_M_DIV64  = 4'h2;
    localparam logic [3:0] MODE_SPI_M_TIMER  = 4'h3;
    localparam logic [3:0] MODE_SPI_S_SEL    = 4'h4;
    localparam logic [3:0] MODE_SPI_S_NOSEL  = 4'h5;
    localparam logic [3:0] MODE_I2C_S_7      = 4'h6;
    localparam logic [3:0] MODE_I2C_S_10     = 4'h7;
    localparam logic [3:0] MODE_I2C_M_RELOAD = 4'h8;
    localparam logic [3:0] MODE_SPI_M_RELOAD = 4'ha;
    localparam logic [3:0] MODE_I2C_M_FW     = 4'hb;
    localparam logic [3:0] MODE_I2C_S_7_SP   = 4'he;
    localparam logic [3:0] MODE_I2C_S_10_SP  = 4'hf;

    localparam logic [10:0] DIV_FOSC4  = 11'h004;
    localparam logic [10:0] DIV_FOSC16 = 11'h010;
    localparam logic [10:0] DIV_FOSC64 = 11'h040;
    localparam logic [10:0] DIV_NONE   = 11'h000;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdi;
        logic ss;
        logic sda;
        logic scl;
    } ssp_route_t;

    typedef struct packed {
        logic spiMaster;
        logic spiSlave;
        logic i2cMaster;
        logic i2cSlave;
        logic tenBit;
        logic startStopIrq;
        logic ssDisabled;
        logic reloadDiv;
        logic reserved;
    } ssp_mode_t;

    function automatic ssp_mode_t ssp_decode(input logic [3:0] code);
        ssp_mode_t f;
        f = '0;
        unique case (code)
            MODE_SPI_M_DIV4, MODE_SPI_M_DIV16,
            MODE_SPI_M_DIV64, MODE_SPI_M_TIMER: f.spiMaster = 1'b1;
            MODE_SPI_S_SEL:    f.spiSlave = 1'b1;
            MODE_SPI_S_NOSEL: begin
                f.spiSlave   = 1'b1;
                f.ssDisabled = 1'b1;
            end
            MODE_I2C_S_7:      f.i2cSlave = 1'b1;
            MODE_I2C_S_10: begin
                f.i2cSlave = 1'b1;
                f.tenBit   = 1'b1;
            end
            MODE_I2C_M_RELOAD: begin
                f.i2cMaster = 1'b1;
                f.reloadDiv = 1'b1;
            end
            MODE_SPI_M_RELOAD: begin
                f.spiMaster = 1'b1;
                f.reloadDiv = 1'b1;
            end
            MODE_I2C_M_FW:     f.i2cMaster = 1'b1;
            MODE_I2C_S_7_SP: begin
                f.i2cSlave     = 1'b1;
                f.startStopIrq = 1'b1;
            end
            MODE_I2C_S_10_SP: begin
                f.i2cSlave     = 1'b1;
                f.tenBit       = 1'b1;
                f.startStopIrq = 1'b1;
            end
            default:           f.reserved = 1'b1;
        endcase
        return f;
    endfunction

    // Serial clock divisor in oscillator cycles; zero means not generated here.
    function automatic logic [10:0] ssp_divisor(input logic [3:0] code,
                                                input logic [7:0] reload);
        logic [8:0] plusOne;
        plusOne = {1'b0, reload} + 9'h001;
        unique case (code)
            MODE_SPI_M_DIV4:                      return DIV_FOSC4;
            MODE_SPI_M_DIV16:                     return DIV_FOSC16;
            MODE_SPI_M_DIV64:                     return DIV_FOSC64;
            MODE_SPI_M_RELOAD, MODE_I2C_M_RELOAD: return {plusOne, 2'b00};
            default:                              return DIV_NONE;
        endcase
    endfunction

endpackage
`default_nettype wire

// ===== logic/ssp_pin_mux.sv
// Pin routing of the serial port signals from enable and mode.
`timescale 1ns/10ps
`default_nettype none
module ssp_pin_mux
    import ssp_pkg::*;
(
    input  wire logic       portEnable,
    input  wire ssp_mode_t  modeFlags,
    output ssp_route_t      route
);

    logic spiOn;
    logic i2cOn;

    assign spiOn = portEnable && (modeFlags.spiMaster || modeFlags.spiSlave);
    assign i2cOn = portEnable && (modeFlags.i2cMaster || modeFlags.i2cSlave);

    always_comb begin
        route     = '0;
        route.sck = spiOn;
        route.sdo = spiOn;
        route.sdi = spiOn;
        // Every SPI mode owns the select pin except the slave that ignores select.
        route.ss  = spiOn && !modeFlags.ssDisabled;
        route.sda = i2cOn;
        route.scl = i2cOn;
    end

endmodule
`default_nettype wire

// ===== dv/ssp_partner.sv
// Behavioural shift engine on the far side of the serial port control block.
`timescale 1ns/10ps
`default_nettype none
module ssp_partner #(
    parameter int BUSY_CYC = 8
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       txLoad,
    input  wire logic       rxReq,
    input  wire logic [7:0] rxByte,
    input  wire logic [1:0] evReq,
    output logic            txBusy,
    output logic            rxByteDone,
    output logic [7:0]      rxData,
    output logic            startSeen,
    output logic            stopSeen
);
    int busyCnt_q;
    assign txBusy = busyCnt_q != 0;
    // Data toggles outside a reception so a stale byte never passes for a fresh one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busyCnt_q  <= 0;
            rxByteDone <= 1'b0;
            rxData     <= 8'h00;
            startSeen  <= 1'b0;
            stopSeen   <= 1'b0;
        end else begin
            busyCnt_q  <= txLoad ? BUSY_CYC : (txBusy ? busyCnt_q - 1 : 0);
            rxByteDone <= rxReq;
            rxData     <= rxReq ? rxByte : ~rxData;
            startSeen  <= evReq[0];
            stopSeen   <= evReq[1];
        end
    end
endmodule
`default_nettype wire

// ===== dv/sync_serial_port_control_tb.sv
// Self-checking bench of the serial port control block.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_control_tb;
    import ssp_pkg::*;
    logic clk = 0, rst = 1, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0, rxReq = 0;
    logic [4:0] awA = '0, arA = '0;
    logic [31:0] wD = '0, rD;
    logic [7:0] rxByte = '0, rxD, txD, b1, b2, rl;
    logic [1:0] evReq = '0, bResp, rResp, resp;
    logic awRdy, wRdy, bV, arRdy, rV, txBusy, rxDone, sS, pS, txLoad, idleHi, sclH, irq, clock_polarity_release;
    logic [3:0] pMode, modeSel;
    ssp_mode_t mF;
    ssp_route_t pR;
    logic [10:0] sDiv;
    logic [33:0] rdQ[$];
    int n_mismatch = 0, n_checks = 0, seed = 34929, nLoad = 0;
    ssp_ctrl_top u_ssp_ctrl_top (.clk(clk), .rst(rst), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
        .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
        .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
        .txBusy(txBusy), .rxByteDone(rxDone), .rxData(rxD), .startSeen(sS),
        .stopSeen(pS), .txLoad(txLoad), .txData(txD), .portMode(pMode), .modeFlags(mF),
        .pinRoute(pR), .sckIdleHigh(idleHi), .sclHold(sclH), .sckDivide(sDiv), .irq(irq));
    ssp_partner u_ssp_partner (.clk(clk), .rst(rst), .txLoad(txLoad), .rxReq(rxReq),
        .rxByte(rxByte), .evReq(evReq), .txBusy(txBusy), .rxByteDone(rxDone),
        .rxData(rxD), .startSeen(sS), .stopSeen(pS));
    initial forever #10 clk = ~clk;
    // ------------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        awA <= a; wD <= {24'h0, d}; awV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
        do begin
            @(posedge clk);
            if (awRdy) awV <= 1'b0;
            if (wRdy) wV <= 1'b0;
            n++;
        end while (!bV && n < 50);
        bR <= 1'b0;
        resp = bResp;
        if (n >= 50) n_mismatch++;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
        int n = 0;
        @(posedge clk);
        rdQ.push_back({r, 24'h0, d});
        arA <= a; arV <= 1'b1; rR <= 1'b1;
        do begin
            @(posedge clk);
            if (arRdy) arV <= 1'b0;
            n++;
        end while (!rV && n < 50);
        rR <= 1'b0;
        if (n >= 50) n_mismatch++;
    endtask
    task automatic rx(input logic [7:0] b);
        @(posedge clk);
        rxReq <= 1'b1; rxByte <= b;
        @(posedge clk);
        rxReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) begin
        logic [33:0] note;
        if (rV && rR) begin
            note = rdQ.pop_front();
            cmp({30'h0, rResp}, {30'h0, note[33:32]});
            cmp(rD, {24'h0, note[7:0]});
        end
    end
    always @(posedge clk) begin
        if (txLoad) nLoad++;
    end
    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial begin
        logic spi, i2c;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL_OFS, CTRL_RST, RESP_OKAY);
        rl = 8'd3 + 8'($unsigned($random(seed)) % 200);
        wr(BAUD_OFS, rl);
        for (int c = 0; c < 32; c++) begin
            clock_polarity_release = 1'($random(seed));
            wr(CTRL_OFS, {2'b00, c[4], clock_polarity_release, c[3:0]});
            @(posedge clk);
            #1;
            spi = c[3:0] <= 4'h5 || c[3:0] == 4'ha;
            i2c = c[3:0] inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
            cmp(32'(pR), c[4] ? {spi, spi, spi, spi && c[3:0] != 4'h5, i2c, i2c} : 0);
            cmp(32'(idleHi), 32'(spi && clock_polarity_release));
            cmp(32'(sclH), 32'(c[4] && c[3:0] inside {4'h6, 4'h7, 4'he, 4'hf} && !clock_polarity_release));
            cmp(32'(sDiv), c[3:0] == 4'h0 ? 4 : c[3:0] == 4'h1 ? 16 : c[3:0] == 4'h2 ? 64 :
                c[3:0] inside {4'h8, 4'ha} ? {rl + 9'h1, 2'b00} : 0);
            cmp(32'(mF.startStopIrq), 32'(c[3:0] inside {4'he, 4'hf}));
            cmp(32'(mF.tenBit), 32'(c[3:0] inside {4'h7, 4'hf}));
            cmp(32'(pMode), 32'(c[3:0]));
        end
        wr(CTRL_OFS, 8'h20);
        wr(MASK_OFS, 8'h01);
        wr(BUF_OFS, 8'h5a);
        wr(BUF_OFS, 8'ha5);
        #1 cmp(32'(irq), 1);
        rd(CTRL_OFS, 8'ha0, RESP_OKAY);
        cmp(32'(txD), 32'h5a);
        cmp(32'(nLoad), 32'h1);
        repeat (10) @(posedge clk);
        wr(STAT_OFS, 8'h0f);
        wr(CTRL_OFS, 8'h20);
        #1 cmp(32'(irq), 0);
        rd(CTRL_OFS, 8'h20, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            modeSel = i == 0 ? 4'h4 : i == 1 ? 4'h6 : 4'h0;
            b1 = 8'($random(seed));
            b2 = ~b1;
            wr(CTRL_OFS, {4'h2, modeSel});
            rx(b1);
            rx(b2);
            rd(CTRL_OFS, {4'h2, modeSel} | (modeSel != 0 ? 8'h40 : 8'h00), RESP_OKAY);
            rd(STAT_OFS, modeSel != 0 ? 8'h02 : 8'h00, RESP_OKAY);
            if (modeSel != 0) rd(BUF_OFS, b1, RESP_OKAY);
            wr(STAT_OFS, 8'h0f);
        end
        for (int i = 0; i < 2; i++) begin
            wr(CTRL_OFS, i == 0 ? 8'h2e : 8'h27);
            @(posedge clk);
            evReq <= 2'b11;
            @(posedge clk);
            evReq <= 2'b00;
            rd(STAT_OFS, i == 0 ? 8'h0c : 8'h00, RESP_OKAY);
            wr(STAT_OFS, 8'h0f);
        end
        wr(5'h14, 8'hff);
        cmp(32'(resp), 32'(RESP_SLVERR));
        rd(5'h14, 8'h00, RESP_SLVERR);
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule
`default_nettype wire
